// *** rtl/sqp_pkg.sv ***
// Constants and carrier types for the switch queue and priority globals block
package sqp_pkg;

  // Register byte addresses; register data sits in the low byte of the word, except the free block count in bits 26:16
  localparam int                    SQP_ADDR_W            = 14;
  localparam logic [SQP_ADDR_W-1:0] SQP_ADDR_PTP_NONEVENT = 14'h037D;
  localparam logic [SQP_ADDR_W-1:0] SQP_ADDR_QUEUE_CTRL   = 14'h0390;
  localparam logic [SQP_ADDR_W-1:0] SQP_ADDR_FREE_BLOCKS  = 14'h03AC;

  // Non-event priority register fields
  localparam int          SQP_NE_OVR_BIT   = 7;
  localparam int          SQP_NE_PRIO_LSB  = 0;
  localparam int          SQP_NE_PRIO_W    = 4;
  localparam logic        SQP_NE_OVR_RST   = 1'b0;
  localparam logic [3:0]  SQP_NE_PRIO_RST  = 4'hF;

  // Queue management control fields
  localparam int          SQP_MAP_LSB      = 6;
  localparam int          SQP_RSVD_HI_LSB  = 2;
  localparam int          SQP_DISCARD_BIT  = 1;
  localparam int          SQP_RSVD_LO_BIT  = 0;
  localparam logic [1:0]  SQP_MAP_RST      = 2'h2;
  localparam logic [3:0]  SQP_RSVD_HI_RST  = 4'h0;
  localparam logic        SQP_DISCARD_RST  = 1'b1;
  localparam logic        SQP_RSVD_LO_RST  = 1'b0;

  // Two-queue mapping codes
  localparam logic [1:0]  SQP_MAP_THREE_LOW = 2'h0;
  localparam logic [1:0]  SQP_MAP_UNUSED    = 2'h1;
  localparam logic [1:0]  SQP_MAP_TWO_LOW   = 2'h2;
  localparam logic [1:0]  SQP_MAP_ONE_LOW   = 2'h3;

  // Free block counter
  localparam int          SQP_FREE_LSB     = 16;
  localparam int          SQP_FREE_W       = 11;
  localparam logic [10:0] SQP_FREE_RST     = 11'h7E8;

  localparam int          SQP_PORTS        = 7;

  typedef struct packed {
    logic                    override;
    logic [SQP_NE_PRIO_W-1:0] prio;
  } sqp_nonevent_type;

  typedef struct packed {
    logic [1:0] two_queue_priority_map;
    logic [3:0] rsvd_hi;
    logic       discard;
    logic       rsvd_lo;
  } sqp_qctrl_type;

  typedef struct packed {
    logic [SQP_ADDR_W-1:0] addr;
    logic [31:0]           wdata;
    logic                  wr;
    logic                  rd;
  } sqp_bus_type;

  typedef struct packed {
    sqp_nonevent_type        nonevent;
    sqp_qctrl_type           qctrl;
    logic [SQP_FREE_W-1:0]   free_block_count;
    logic [31:0]             rdata;
    logic [3:0]              prio;
    logic [1:0]              queue;
    logic [SQP_PORTS-1:0]    fwd_map;
    logic                    drop;
  } sqp_state_type;

endpackage

// *** rtl/sqp_queue_map.sv ***
// Collapse of a regenerated 2-bit priority onto the low and high queues
`timescale 1ns/1ps
`default_nettype none

module sqp_queue_map
  import sqp_pkg::*;
(
  input  wire logic [1:0] map_code_i,  // Two-queue mapping code
  input  wire logic [1:0] regen_prio_i, // Regenerated priority
  output logic            high_o        // 1 = high queue
);

  always_comb begin
    unique case (map_code_i)
      SQP_MAP_THREE_LOW: high_o = (regen_prio_i == 2'h3);
      SQP_MAP_ONE_LOW:   high_o = (regen_prio_i != 2'h0);
      // Unused code falls back to the even split
      default:           high_o = regen_prio_i[1];
    endcase
  end

endmodule

`default_nettype wire

// *** rtl/sqp_globals.sv ***
// Global queue, priority and packet memory registers of the switch core
//
// What this block does
// - With the non-event override clear, non-event time messages keep their QoS priority.
// - With the override set, every non-event time message takes the configured priority.
// - The forced priority is a 4-bit read-write field in bits 3:0, reset to all ones.
// - In two-queue mode a 2-bit map field in bits 7:6, reset to 10, collapses priority.
// - Map code 00 sends priorities 0 to 2 low and 3 high.
// - Map code 10 sends priorities 0 and 1 low and 2 and 3 high.
// - Map code 11 sends only priority 0 low and 1 to 3 high.
// - With the discard bit set, its reset state, frames stay within membership ports.
// - With the discard bit clear, single-destination frames ignore membership.
// - With discard clear and mirroring on, a mirrored single-destination frame drops.
// - An 11-bit read-only field in bits 26:16 shows the free packet memory blocks.
// - The free-block count resets to its maximum, the empty-switch value.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module sqp_globals
  import sqp_pkg::*;
(
  input  wire logic                  clock_i,          // Core clock, 100 MHz
  input  wire logic                  rst_i,            // Synchronous reset, active high
  input  wire logic [SQP_ADDR_W-1:0] addr_i,           // Byte address
  input  wire logic [31:0]           wdata_i,          // Write data
  input  wire logic                  wr_i,             // Write strobe
  input  wire logic                  rd_i,             // Read strobe
  output logic      [31:0]           rdata_o,          // Read data, cycle after read
  input  wire logic                  nonevent_msg_i,   // Frame is a non-event time message
  input  wire logic [3:0]            qos_prio_i,       // Priority from QoS classification
  output logic      [3:0]            queue_prio_o,     // Priority used on queuing
  input  wire logic                  two_queue_sel_i,  // Two-queue configuration selected
  input  wire logic [1:0]            regen_prio_i,     // Regenerated 2-bit priority
  output logic      [1:0]            queue_o,          // Egress queue chosen
  input  wire logic [SQP_PORTS-1:0]  dest_map_i,       // Lookup destination ports
  input  wire logic [SQP_PORTS-1:0]  member_map_i,     // Port membership set
  input  wire logic                  mirror_en_i,      // Mirroring enabled
  input  wire logic                  mirrored_i,       // Frame mirrored to another port
  output logic      [SQP_PORTS-1:0]  fwd_map_o,        // Ports the frame goes to
  output logic                       drop_o,           // Frame dropped
  input  wire logic                  blk_alloc_i,      // One block buffered
  input  wire logic                  blk_release_i,    // One block released
  output logic      [SQP_FREE_W-1:0] free_blocks_o     // Current free blocks
);

  sqp_state_type state_q;
  sqp_state_type state_d;
  sqp_bus_type   bus;
  logic          map_high;
  logic          single_dest;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // Exactly one destination bit set
  assign single_dest = (dest_map_i != '0) &&
                       ((dest_map_i & (dest_map_i - SQP_PORTS'(1))) == '0);

  sqp_queue_map u_queue_map (
    .map_code_i   (state_q.qctrl.two_queue_priority_map),
    .regen_prio_i (regen_prio_i),
    .high_o       (map_high)
  );

  always_comb begin
    state_d       = state_q;
    state_d.rdata = 32'h0000_0000;

    // Register writes
    if (bus.wr) begin
      unique case (bus.addr)
        SQP_ADDR_PTP_NONEVENT: begin
          state_d.nonevent.override = bus.wdata[SQP_NE_OVR_BIT];
          state_d.nonevent.prio     =
            bus.wdata[SQP_NE_PRIO_LSB +: SQP_NE_PRIO_W];
        end
        SQP_ADDR_QUEUE_CTRL: begin
          state_d.qctrl.two_queue_priority_map = bus.wdata[SQP_MAP_LSB +: 2];
          state_d.qctrl.rsvd_hi = bus.wdata[SQP_RSVD_HI_LSB +: 4];
          state_d.qctrl.discard = bus.wdata[SQP_DISCARD_BIT];
          state_d.qctrl.rsvd_lo = bus.wdata[SQP_RSVD_LO_BIT];
        end
        // Free-block register is read-only
        default: begin
          state_d.nonevent = state_q.nonevent;
        end
      endcase
    end

    // Register reads, answered in the following cycle only
    if (bus.rd) begin
      unique case (bus.addr)
        SQP_ADDR_PTP_NONEVENT: begin
          state_d.rdata[SQP_NE_OVR_BIT] = state_q.nonevent.override;
          state_d.rdata[SQP_NE_PRIO_LSB +: SQP_NE_PRIO_W] = state_q.nonevent.prio;
        end
        SQP_ADDR_QUEUE_CTRL: begin
          state_d.rdata[SQP_MAP_LSB +: 2]     = state_q.qctrl.two_queue_priority_map;
          state_d.rdata[SQP_RSVD_HI_LSB +: 4] = state_q.qctrl.rsvd_hi;
          state_d.rdata[SQP_DISCARD_BIT]      = state_q.qctrl.discard;
          state_d.rdata[SQP_RSVD_LO_BIT]      = state_q.qctrl.rsvd_lo;
        end
        SQP_ADDR_FREE_BLOCKS: begin
          state_d.rdata[SQP_FREE_LSB +: SQP_FREE_W] = state_q.free_block_count;
        end
        default: begin
          state_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Queuing priority for non-event time messages
    if (nonevent_msg_i && state_q.nonevent.override) begin
      state_d.prio = state_q.nonevent.prio;
    end else begin
      state_d.prio = qos_prio_i;
    end

    // Queue selection
    if (two_queue_sel_i) begin
      state_d.queue = {1'b0, map_high};
    end else begin
      state_d.queue = regen_prio_i;
    end

    // Membership filtering of forwarded frames
    state_d.drop = 1'b0;
    if (state_q.qctrl.discard || !single_dest) begin
      state_d.fwd_map = dest_map_i & member_map_i;
    end else if (mirror_en_i && mirrored_i) begin
      state_d.fwd_map = '0;
      state_d.drop    = 1'b1;
    end else begin
      state_d.fwd_map = dest_map_i;
    end

    // Free block accounting, saturating at both ends
    if (blk_alloc_i && !blk_release_i && state_q.free_block_count != '0) begin
      state_d.free_block_count = state_q.free_block_count - SQP_FREE_W'(1);
    end else if (blk_release_i && !blk_alloc_i &&
                 state_q.free_block_count != SQP_FREE_RST) begin
      state_d.free_block_count = state_q.free_block_count + SQP_FREE_W'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q.nonevent.override            <= SQP_NE_OVR_RST;
      state_q.nonevent.prio                <= SQP_NE_PRIO_RST;
      state_q.qctrl.two_queue_priority_map <= SQP_MAP_RST;
      state_q.qctrl.rsvd_hi                <= SQP_RSVD_HI_RST;
      state_q.qctrl.discard                <= SQP_DISCARD_RST;
      state_q.qctrl.rsvd_lo                <= SQP_RSVD_LO_RST;
      state_q.free_block_count             <= SQP_FREE_RST;
      state_q.rdata                        <= 32'h0000_0000;
      state_q.prio                         <= 4'h0;
      state_q.queue                        <= 2'h0;
      state_q.fwd_map                      <= '0;
      state_q.drop                         <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rdata_o       = state_q.rdata;
  assign queue_prio_o  = state_q.prio;
  assign queue_o       = state_q.queue;
  assign fwd_map_o     = state_q.fwd_map;
  assign drop_o        = state_q.drop;
  assign free_blocks_o = state_q.free_block_count;

endmodule

`default_nettype wire

// *** tb/sqp_globals_sva.sv ***
// Port-level assertions for the queue and priority globals block
`timescale 1ns/1ps
`default_nettype none
module sqp_globals_sva
  import sqp_pkg::*;
(
  input wire logic                  clock_i,         // Clock
  input wire logic                  rst_i,           // Reset
  input wire logic [SQP_ADDR_W-1:0] addr_i,          // Address
  input wire logic                  rd_i,            // Read strobe
  input wire logic [31:0]           rdata_o,         // Read data
  input wire logic                  nonevent_msg_i,  // Non-event frame
  input wire logic [3:0]            qos_prio_i,      // QoS priority
  input wire logic [3:0]            queue_prio_o,    // Queuing priority
  input wire logic                  two_queue_sel_i, // Two-queue mode
  input wire logic [1:0]            regen_prio_i,    // Regenerated priority
  input wire logic [1:0]            queue_o,         // Queue
  input wire logic [SQP_PORTS-1:0]  dest_map_i,      // Destinations
  input wire logic [SQP_PORTS-1:0]  member_map_i,    // Membership
  input wire logic                  mirror_en_i,     // Mirroring on
  input wire logic [SQP_PORTS-1:0]  fwd_map_o,       // Forward ports
  input wire logic                  drop_o,          // Drop
  input wire logic                  blk_alloc_i,     // Block buffered
  input wire logic                  blk_release_i,   // Block released
  input wire logic [SQP_FREE_W-1:0] free_blocks_o    // Free blocks
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_prio_from_qos: assert property (!$past(rst_i) && $past(!nonevent_msg_i)
    |-> queue_prio_o == $past(qos_prio_i)) else $error("queue priority not from QoS");
  a_two_q_low: assert property (!$past(rst_i) && $past(two_queue_sel_i && regen_prio_i == 2'h0)
    |-> queue_o == 2'h0) else $error("priority 0 not on low queue");
  a_two_q_high: assert property (!$past(rst_i) && $past(two_queue_sel_i && regen_prio_i == 2'h3)
    |-> queue_o == 2'h1) else $error("priority 3 not on high queue");
  a_four_q_pass: assert property (!$past(rst_i) && $past(!two_queue_sel_i)
    |-> queue_o == $past(regen_prio_i)) else $error("queue not regenerated priority");
  a_multi_member: assert property (!$past(rst_i) && $countones($past(dest_map_i)) != 1
    |-> fwd_map_o == $past(dest_map_i & member_map_i)) else $error("multi-dest not masked");
  a_no_mirror_drop: assert property (!$past(rst_i) && $past(!mirror_en_i) |-> !drop_o)
    else $error("drop without mirroring");
  a_free_down: assert property (!$past(rst_i) && $past(blk_alloc_i && !blk_release_i)
    && $past(free_blocks_o) != 11'h0 |-> free_blocks_o == $past(free_blocks_o) - 11'h1)
    else $error("free count did not fall");
  a_free_up: assert property (!$past(rst_i) && $past(blk_release_i && !blk_alloc_i)
    && $past(free_blocks_o) != 11'h7E8 |-> free_blocks_o == $past(free_blocks_o) + 11'h1)
    else $error("free count did not rise");
  a_free_hold: assert property (!$past(rst_i) && $past(blk_alloc_i == blk_release_i)
    |-> $stable(free_blocks_o)) else $error("free count moved");
  a_free_read: assert property (!$past(rst_i) && $past(rd_i && addr_i == 14'h03AC)
    |-> rdata_o == {5'h00, $past(free_blocks_o), 16'h0000}) else $error("free read wrong");
endmodule
bind sqp_globals sqp_globals_sva u_sva (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .nonevent_msg_i(nonevent_msg_i), .qos_prio_i(qos_prio_i),
  .queue_prio_o(queue_prio_o), .two_queue_sel_i(two_queue_sel_i), .regen_prio_i(regen_prio_i),
  .queue_o(queue_o), .dest_map_i(dest_map_i), .member_map_i(member_map_i),
  .mirror_en_i(mirror_en_i), .fwd_map_o(fwd_map_o), .drop_o(drop_o),
  .blk_alloc_i(blk_alloc_i), .blk_release_i(blk_release_i), .free_blocks_o(free_blocks_o));
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the queue and priority globals block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sqp_pkg::*;
  logic                  clock_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [SQP_ADDR_W-1:0] addr_i = '0;
  logic [31:0]           wdata_i = '0, rdata_o;
  logic                  nonevent_msg_i = 1'b0, two_queue_sel_i = 1'b0, drop_o;
  logic                  mirror_en_i = 1'b0, mirrored_i = 1'b0;
  logic                  blk_alloc_i = 1'b0, blk_release_i = 1'b0;
  logic [3:0]            qos_prio_i = 4'h0, queue_prio_o;
  logic [1:0]            regen_prio_i = 2'h0, queue_o;
  logic [SQP_PORTS-1:0]  dest_map_i = '0, member_map_i = '0, fwd_map_o;
  logic [SQP_FREE_W-1:0] free_blocks_o;
  int                    err_total = 0, num_checks = 0;
  sqp_globals u_dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .nonevent_msg_i(nonevent_msg_i),
    .qos_prio_i(qos_prio_i), .queue_prio_o(queue_prio_o), .two_queue_sel_i(two_queue_sel_i),
    .regen_prio_i(regen_prio_i), .queue_o(queue_o), .dest_map_i(dest_map_i),
    .member_map_i(member_map_i), .mirror_en_i(mirror_en_i), .mirrored_i(mirrored_i),
    .fwd_map_o(fwd_map_o), .drop_o(drop_o), .blk_alloc_i(blk_alloc_i),
    .blk_release_i(blk_release_i), .free_blocks_o(free_blocks_o));
  always #5 clock_i = ~clock_i;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle;
    @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [13:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(what, rdata_o, exp);
  endtask
  task automatic t_regs;
    chk("free reset", 32'(free_blocks_o), 32'h0000_07E8);
    rchk("nonevent reset", 14'h037D, 32'h0000_000F);
    rchk("qctrl reset", 14'h0390, 32'h0000_0082);
    rchk("free reg", 14'h03AC, 32'h07E8_0000);
    wr(14'h037D, 32'hFFFF_FFFF);
    rchk("nonevent rw", 14'h037D, 32'h0000_008F);
    wr(14'h0390, 32'hFFFF_FF3F);
    rchk("qctrl rw", 14'h0390, 32'h0000_003F);
    wr(14'h03AC, 32'h0000_0000);
    rchk("free ro", 14'h03AC, 32'h07E8_0000);
    rchk("unmapped", 14'h0394, 32'h0000_0000);
  endtask
  task automatic t_prio;
    wr(14'h037D, 32'h0000_0085);
    @(posedge clock_i);
    nonevent_msg_i <= 1'b1;
    qos_prio_i <= 4'h2;
    settle;
    chk("forced prio", 32'(queue_prio_o), 32'h0000_0005);
    wr(14'h037D, 32'h0000_0005);
    settle;
    chk("qos prio", 32'(queue_prio_o), 32'h0000_0002);
  endtask
  task automatic t_map;
    logic [1:0] codes [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    int         thr [4] = '{2, 1, 1, 0};
    for (int c = 0; c < 4; c++) begin
      wr(14'h0390, {24'h0, codes[c], 6'h02});
      for (int p = 0; p < 4; p++) begin
        @(posedge clock_i);
        two_queue_sel_i <= 1'b1;
        regen_prio_i <= p[1:0];
        settle;
        chk("queue", 32'(queue_o), (p > thr[c]) ? 32'h1 : 32'h0);
      end
    end
  endtask
  task automatic t_member;
    @(posedge clock_i);
    dest_map_i <= 7'h04;
    member_map_i <= 7'h03;
    settle;
    chk("member fwd", 32'(fwd_map_o), 32'h0000_0000);
    wr(14'h0390, 32'h0000_0080);
    settle;
    chk("single fwd", 32'(fwd_map_o), 32'h0000_0004);
    chk("no drop", 32'(drop_o), 32'h0000_0000);
    @(posedge clock_i);
    mirror_en_i <= 1'b1;
    mirrored_i <= 1'b1;
    settle;
    chk("mirror drop", 32'(drop_o), 32'h0000_0001);
    chk("mirror fwd", 32'(fwd_map_o), 32'h0000_0000);
  endtask
  task automatic t_free;
    @(posedge clock_i);
    blk_alloc_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    blk_alloc_i <= 1'b0;
    blk_release_i <= 1'b1;
    @(posedge clock_i);
    blk_alloc_i <= 1'b1;
    @(posedge clock_i);
    blk_alloc_i <= 1'b0;
    blk_release_i <= 1'b0;
    settle;
    chk("free count", 32'(free_blocks_o), 32'h0000_07E6);
    rchk("free live", 14'h03AC, 32'h07E6_0000);
    @(posedge clock_i);
    blk_release_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    blk_release_i <= 1'b0;
    settle;
    chk("free max", 32'(free_blocks_o), 32'h0000_07E8);
  endtask
  task automatic give_verdict;
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    t_regs;
    t_prio;
    t_map;
    t_member;
    t_free;
    give_verdict;
  end
  initial begin
    #100000;
    err_total++;
    give_verdict;
  end
endmodule
`default_nettype wire
